/* File: rtl/rea_pkg.sv */
// Constants and carrier types of the reactive energy accumulator
`default_nettype none

package rea_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int PHASES      = 3;
  localparam int SAMPLE_W    = 24;
  localparam int GAIN_W      = 12;
  localparam int OFFSET_W    = 12;
  localparam int DIV_W       = 8;
  localparam int ACC_W       = 41;
  localparam int ENERGY_W    = 16;
  localparam int ADDR_W      = 5;
  localparam int DATA_W      = 32;
  localparam int POWER_W     = 27;
  localparam int HOLD_W      = 21;

  // ---------------------------------------------------------------
  // Register indices on the plain register port
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_GAIN_A     = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_B     = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_C     = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_A   = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_B   = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_C   = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_DIVIDER    = 5'h06;
  localparam logic [ADDR_W-1:0] ADDR_ENERGY_A   = 5'h07;
  localparam logic [ADDR_W-1:0] ADDR_ENERGY_B   = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_ENERGY_C   = 5'h09;
  localparam logic [ADDR_W-1:0] ADDR_COMP_MODE  = 5'h0a;
  localparam logic [ADDR_W-1:0] ADDR_LINE_MODE  = 5'h0b;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_MASK       = 5'h0d;
  localparam logic [ADDR_W-1:0] ADDR_INTEG      = 5'h0e;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CONNECTION_SELECT_LSB      = 0;
  localparam int INCLUDE_LSB     = 2;
  localparam int READ_CLEARS_BIT = 6;
  localparam int SIGN_FLAG_BIT   = 18;
  localparam int HALF_FLAG_BIT   = 1;
  localparam int INTEG_ON_BIT    = 0;
  localparam int HALF_ACC_BIT    = ACC_W - ENERGY_W + 14;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [1:0]       CONNECTION_SELECT_RESET   = 2'h0;
  localparam logic [2:0]       INCLUDE_RESET  = 3'h7;
  localparam logic [1:0]       CONNECTION_SELECT_OWN     = 2'h0;
  localparam logic [1:0]       CONNECTION_SELECT_DIFF_BC = 2'h1;
  localparam logic [1:0]       CONNECTION_SELECT_DIFF_A  = 2'h2;
  localparam logic [1:0]       CONNECTION_SELECT_RSVD    = 2'h3;
  localparam logic [13:0]      GAIN_UNITY     = 14'h1000;
  localparam logic [POWER_W-1:0] SIGN_MAG_LIMIT = 27'h2000000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int SAMPLE_PERIOD   = 4;
  localparam int SIGN_HOLD_MS    = 160;
  localparam int SIGN_HOLD_CYC   = SIGN_HOLD_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PHASES-1:0][SAMPLE_W-1:0] own;    // Vx times own shifted current
    logic [1:0][SAMPLE_W-1:0]        crossB; // VA, VC times shifted IB
  } rea_samples_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rea_bus_t;

endpackage : rea_pkg

`default_nettype wire

/* File: rtl/rea_accumulator.sv */
// Per-phase reactive power scaling, sign watch and energy accumulation
// Notes on behaviour
// - Phase power is multiplied by one plus signed gain over 4096.
// - Gain 0x800 halves the power, 0x7FF raises it by half.
// - Signed 12-bit offset per phase is added to the scaled power.
// - Sign flag bit 18 sets on any sign change of a monitored phase.
// - Only phases enabled by the include field take part in sign watch.
// - Set sign flag with its mask bit set drives the interrupt low.
// - Sign change needs 160 ms plus 2^25 summed magnitude, in 4-clock steps.
// - Positive sign for voltage leading current, either integrator setting.
// - Shift filter uses minus 90 with integrator on, plus 90 when off.
// - 41-bit accumulator per phase; energy register shows its upper 16 bits.
// - Accumulation is signed; negative power lowers the accumulator.
// - Power divided by the 8-bit divider; 0 or 1 pass undivided.
// - One sample added every four master clock periods.
// - Energy wraps positive to 0x8000 and negative to 0x7FFF.
// - Change of energy bit 14 flags half-full; mask bit 1 enables interrupt.
// - With read-clears bit 6 set, reading an energy register zeroes it.
// - Connection select picks own products or differences against phase B.
// - Include field sits at bits 2 to 4 of the computation mode register.
`timescale 1ns/100ps
`default_nettype none

module rea_accumulator
  import rea_pkg::*;
#(
  parameter int SIGN_HOLD_CYCLES = SIGN_HOLD_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire rea_samples_t      samples,
  input  wire rea_bus_t          bus,
  output logic [DATA_W-1:0]      readData,
  output logic                   irqN,
  output logic                   phaseShiftNeg
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                      tickCnt;
    logic [PHASES-1:0][GAIN_W-1:0]   gain;
    logic [PHASES-1:0][OFFSET_W-1:0] offset;
    logic [DIV_W-1:0]                divider;
    logic [PHASES-1:0][ACC_W-1:0]    acc;
    logic [1:0]                      connection_select;
    logic [2:0]                      phaseInclude;
    logic                            readClears;
    logic                            integOn;
    logic                            signFlag;
    logic                            halfFlag;
    logic                            signMask;
    logic                            halfMask;
    logic [PHASES-1:0]               signNeg;
    logic [PHASES-1:0][HOLD_W-1:0]   holdCnt;
    logic [PHASES-1:0][POWER_W-1:0]  magSum;
    logic [DATA_W-1:0]               readData;
    logic                            irqN;
    logic                            phaseShiftNeg;
  } rea_state_t;

  rea_state_t s;
  rea_state_t next_s;

  localparam logic [HOLD_W-1:0] HOLD_LIMIT = HOLD_W'(SIGN_HOLD_CYCLES);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // One process for the whole datapath; phases share the divider, mode fields, sample tick and status flags
  always_comb begin
    logic                            tick;
    logic [PHASES-1:0][SAMPLE_W:0]   sel;
    logic signed [SAMPLE_W:0]        selS;
    logic signed [13:0]              gainFactor;
    logic signed [38:0]              product;
    logic signed [POWER_W-1:0]       power;
    logic signed [POWER_W-1:0]       divisor;
    logic signed [POWER_W-1:0]       quotient;
    logic [POWER_W-1:0]              magnitude;
    logic                            rawNeg;
    logic                            halfEvent;
    logic                            signEvent;
    tick       = 1'b0;
    sel        = '0;
    selS       = '0;
    gainFactor = '0;
    product    = '0;
    power      = '0;
    divisor    = '0;
    quotient   = '0;
    magnitude  = '0;
    rawNeg     = 1'b0;
    halfEvent  = 1'b0;
    signEvent  = 1'b0;
    next_s     = s;

    // Four-clock sample cadence
    tick           = (s.tickCnt == 2'(SAMPLE_PERIOD - 1));
    next_s.tickCnt = s.tickCnt + 2'h1;

    // Accumulator inputs by connection mode; B carries no term in 3-wire modes
    unique case (s.connection_select)
      CONNECTION_SELECT_OWN: begin
        for (int p = 0; p < PHASES; p++) begin
          sel[p] = {samples.own[p][SAMPLE_W-1], samples.own[p]};
        end
      end
      CONNECTION_SELECT_DIFF_BC: begin
        sel[0] = $signed({samples.own[0][SAMPLE_W-1], samples.own[0]})
               - $signed({samples.crossB[0][SAMPLE_W-1], samples.crossB[0]});
        sel[1] = '0;
        sel[2] = $signed({samples.own[2][SAMPLE_W-1], samples.own[2]})
               - $signed({samples.crossB[1][SAMPLE_W-1], samples.crossB[1]});
      end
      CONNECTION_SELECT_DIFF_A: begin
        sel[0] = $signed({samples.own[0][SAMPLE_W-1], samples.own[0]})
               - $signed({samples.crossB[0][SAMPLE_W-1], samples.crossB[0]});
        sel[1] = '0;
        sel[2] = {samples.own[2][SAMPLE_W-1], samples.own[2]};
      end
      CONNECTION_SELECT_RSVD: begin
        sel = '0;                                  // Reserved code feeds nothing
      end
    endcase

    // Register port writes; events are merged afterwards so a set wins
    if (bus.wr) begin
      unique case (bus.addr)
        ADDR_GAIN_A:    next_s.gain[0]   = bus.wdata[GAIN_W-1:0];
        ADDR_GAIN_B:    next_s.gain[1]   = bus.wdata[GAIN_W-1:0];
        ADDR_GAIN_C:    next_s.gain[2]   = bus.wdata[GAIN_W-1:0];
        ADDR_OFFSET_A:  next_s.offset[0] = bus.wdata[OFFSET_W-1:0];
        ADDR_OFFSET_B:  next_s.offset[1] = bus.wdata[OFFSET_W-1:0];
        ADDR_OFFSET_C:  next_s.offset[2] = bus.wdata[OFFSET_W-1:0];
        ADDR_DIVIDER:   next_s.divider   = bus.wdata[DIV_W-1:0];
        ADDR_COMP_MODE: begin
          next_s.connection_select  = bus.wdata[CONNECTION_SELECT_LSB +: 2];
          next_s.phaseInclude = bus.wdata[INCLUDE_LSB +: 3];
        end
        ADDR_LINE_MODE: next_s.readClears = bus.wdata[READ_CLEARS_BIT];
        ADDR_STATUS: begin
          // Write one to clear
          if (bus.wdata[SIGN_FLAG_BIT]) next_s.signFlag = 1'b0;
          if (bus.wdata[HALF_FLAG_BIT]) next_s.halfFlag = 1'b0;
        end
        ADDR_MASK: begin
          next_s.signMask = bus.wdata[SIGN_FLAG_BIT];
          next_s.halfMask = bus.wdata[HALF_FLAG_BIT];
        end
        ADDR_INTEG:     next_s.integOn = bus.wdata[INTEG_ON_BIT];
        default: begin
        end
      endcase
    end

    // Per-phase datapath, identical for every phase
    for (int p = 0; p < PHASES; p++) begin
      selS       = $signed(sel[p]);
      // Unity plus signed gain: 0x800 gives 0.5, 0x7ff gives about 1.5
      gainFactor = $signed(GAIN_UNITY) + $signed({{2{s.gain[p][GAIN_W-1]}}, s.gain[p]});
      product    = 39'(selS * gainFactor);
      // Offset added after gain so a calibrated idle phase reads zero
      power      = $signed(product[38:12])
                 + $signed({{(POWER_W-OFFSET_W){s.offset[p][OFFSET_W-1]}}, s.offset[p]});
      // Sign taken straight from the power after offset; no inversion for integrator
      rawNeg     = power[POWER_W-1];
      magnitude  = rawNeg ? POWER_W'(-power) : POWER_W'(power);

      // Divider of 0 or 1 passes power through untouched
      divisor    = $signed({{(POWER_W-DIV_W){1'b0}}, s.divider});
      quotient   = (s.divider > 8'h01) ? POWER_W'(power / divisor) : power;

      // Signed add into a wrapping accumulator
      if (tick) begin
        next_s.acc[p] = s.acc[p] + {{(ACC_W-POWER_W){quotient[POWER_W-1]}}, quotient};
      end

      // Sign watch: hold time, then enough summed magnitude, before flipping
      if (!s.phaseInclude[p]) begin
        next_s.signNeg[p] = rawNeg;
        next_s.holdCnt[p] = '0;
        next_s.magSum[p]  = '0;
      end else if (rawNeg == s.signNeg[p]) begin
        next_s.holdCnt[p] = '0;
        next_s.magSum[p]  = '0;
      end else if (s.holdCnt[p] < HOLD_LIMIT) begin
        next_s.holdCnt[p] = s.holdCnt[p] + 21'h1;
      end else if (tick) begin
        if (s.magSum[p] + magnitude >= SIGN_MAG_LIMIT) begin
          next_s.signNeg[p] = rawNeg;
          next_s.holdCnt[p] = '0;
          next_s.magSum[p]  = '0;
          signEvent         = 1'b1;
        end else begin
          next_s.magSum[p] = s.magSum[p] + magnitude;
        end
      end
    end

    // Read path; data stand in the following cycle only
    next_s.readData = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_GAIN_A:    next_s.readData = {20'h0, s.gain[0]};
        ADDR_GAIN_B:    next_s.readData = {20'h0, s.gain[1]};
        ADDR_GAIN_C:    next_s.readData = {20'h0, s.gain[2]};
        ADDR_OFFSET_A:  next_s.readData = {20'h0, s.offset[0]};
        ADDR_OFFSET_B:  next_s.readData = {20'h0, s.offset[1]};
        ADDR_OFFSET_C:  next_s.readData = {20'h0, s.offset[2]};
        ADDR_DIVIDER:   next_s.readData = {24'h0, s.divider};
        ADDR_ENERGY_A:  next_s.readData = {16'h0, s.acc[0][ACC_W-1 -: ENERGY_W]};
        ADDR_ENERGY_B:  next_s.readData = {16'h0, s.acc[1][ACC_W-1 -: ENERGY_W]};
        ADDR_ENERGY_C:  next_s.readData = {16'h0, s.acc[2][ACC_W-1 -: ENERGY_W]};
        ADDR_COMP_MODE: next_s.readData = {27'h0, s.phaseInclude, s.connection_select};
        ADDR_LINE_MODE: next_s.readData = {25'h0, s.readClears, 6'h0};
        ADDR_STATUS:    next_s.readData = {13'h0, s.signFlag, 16'h0, s.halfFlag, 1'b0};
        ADDR_MASK:      next_s.readData = {13'h0, s.signMask, 16'h0, s.halfMask, 1'b0};
        ADDR_INTEG:     next_s.readData = {31'h0, s.integOn};
        default:        next_s.readData = '0;
      endcase
      // Clear replaces any sample landing in the same cycle; value read is kept
      if (s.readClears) begin
        for (int p = 0; p < PHASES; p++) begin
          if (bus.addr == ADDR_ENERGY_A + 5'(p)) begin
            next_s.acc[p] = '0;
          end
        end
      end
    end

    // Half-full: bit 14 of any energy register changed
    for (int p = 0; p < PHASES; p++) begin
      if (next_s.acc[p][HALF_ACC_BIT] != s.acc[p][HALF_ACC_BIT]) begin
        halfEvent = 1'b1;
      end
    end

    // Events set after the clear so a coinciding event is not lost
    if (signEvent) next_s.signFlag = 1'b1;
    if (halfEvent) next_s.halfFlag = 1'b1;

    // Interrupt from the flags as they will stand next cycle
    next_s.irqN = !((next_s.signFlag && next_s.signMask)
                 || (next_s.halfFlag && next_s.halfMask));

    // Shift direction handed to the current phase-shift filter
    next_s.phaseShiftNeg = next_s.integOn;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Synchronous reset; control comes up in own-phase mode, all included
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s            <= '0;
      s.connection_select     <= CONNECTION_SELECT_RESET;
      s.phaseInclude <= INCLUDE_RESET;
      s.irqN       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // All straight from the state register
  assign readData      = s.readData;
  assign irqN          = s.irqN;
  assign phaseShiftNeg = s.phaseShiftNeg;

endmodule : rea_accumulator

`default_nettype wire

/* File: tb/rea_accumulator_chk.sv */
// Checker: port-level properties of the reactive energy accumulator
`timescale 1ns/100ps
`default_nettype none

module rea_accumulator_chk
  import rea_pkg::*;
#(
  parameter int SIGN_HOLD_CYCLES = SIGN_HOLD_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire rea_samples_t      samples,
  input  wire rea_bus_t          bus,
  input  wire logic [DATA_W-1:0] readData,
  input  wire logic              irqN,
  input  wire logic              phaseShiftNeg
);
  // ----------
  // Shadows
  // ----------
  logic [1:0] maskQ;
  logic [4:0] compQ;

  // Copies of host writes, so read-back and masking can be judged
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      maskQ <= 2'h0;
      compQ <= {INCLUDE_RESET, CONNECTION_SELECT_RESET};
    end else if (bus.wr) begin
      if (bus.addr == ADDR_MASK) maskQ <= {bus.wdata[SIGN_FLAG_BIT], bus.wdata[HALF_FLAG_BIT]};
      if (bus.addr == ADDR_COMP_MODE) compQ <= bus.wdata[4:0];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------
  // Properties
  // ----------
  chk_read_idle_zero: assert property (!bus.rd |=> readData == 32'h0)
    else $error("read data not zero outside a read");
  chk_gain_offset_width: assert property (bus.rd && bus.addr <= ADDR_OFFSET_C |=> readData[31:12] == 20'h0)
    else $error("gain or offset read wider than 12 bits");
  chk_divider_width: assert property (bus.rd && bus.addr == ADDR_DIVIDER |=> readData[31:8] == 24'h0)
    else $error("divider read wider than 8 bits");
  chk_energy_width: assert property (bus.rd && bus.addr inside {[ADDR_ENERGY_A:ADDR_ENERGY_C]}
    |=> readData[31:16] == 16'h0)
    else $error("energy read wider than 16 bits");
  chk_mode_readback: assert property (bus.rd && bus.addr == ADDR_COMP_MODE |=> readData == {27'h0, compQ})
    else $error("mode field read-back differs");
  chk_status_bits: assert property (bus.rd && bus.addr == ADDR_STATUS |=> (readData & ~32'h40002) == 32'h0)
    else $error("status shows an unknown flag");
  chk_mask_quiet: assert property (maskQ == 2'h0 |-> irqN)
    else $error("interrupt low with all masks clear");
  chk_irq_release: assert property ($rose(irqN) |-> $past(bus.wr))
    else $error("interrupt released without a host write");
  chk_shift_follow: assert property (bus.wr && bus.addr == ADDR_INTEG
    |=> phaseShiftNeg == $past(bus.wdata[INTEG_ON_BIT]))
    else $error("shift direction does not follow integrator");
  chk_shift_hold: assert property (!(bus.wr && bus.addr == ADDR_INTEG) |=> $stable(phaseShiftNeg))
    else $error("shift direction moved without a write");
endmodule // rea_accumulator_chk

bind rea_accumulator rea_accumulator_chk #(.SIGN_HOLD_CYCLES(SIGN_HOLD_CYCLES)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .samples(samples), .bus(bus),
  .readData(readData), .irqN(irqN), .phaseShiftNeg(phaseShiftNeg));

`default_nettype wire

/* File: tb/rea_host_model.sv */
// Host model: software master on the register port
`timescale 1ns/100ps
`default_nettype none

module rea_host_model
  import rea_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic [DATA_W-1:0] readData,
  output var  rea_bus_t          bus
);
  // ----------
  // Transfers
  // ----------
  // One strobe then an idle cycle; a current gain is never programmed
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk);
    bus <= '0;
    @(negedge ref_clk);
    q = readData; // Read data stand only in this cycle
    @(posedge ref_clk);
  endtask

  initial bus = '0;
endmodule // rea_host_model

`default_nettype wire

/* File: tb/rea_accumulator_tb_top.sv */
// Testbench: register map, phase energy, sign and half-full events
`timescale 1ns/100ps
`default_nettype none

module rea_accumulator_tb_top
  import rea_pkg::*;
;
  localparam int K = 20; // Ticks per window; not a multiple of 8 so a tick of slack is harmless
  logic              ref_clk;
  logic              rst;
  rea_samples_t      samples;
  rea_bus_t          bus;
  logic [DATA_W-1:0] readData;
  logic              irqN;
  logic              phaseShiftNeg;
  int                nErrors;
  int                testsRun;
  int                seed;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  rea_accumulator #(.SIGN_HOLD_CYCLES(8)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .samples(samples), .bus(bus),
    .readData(readData), .irqN(irqN), .phaseShiftNeg(phaseShiftNeg));
  rea_host_model i_host (.ref_clk(ref_clk), .readData(readData), .bus(bus));

  // ----------
  // Helpers
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] v;
    i_host.xfer(1'b1, a, d, v);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    i_host.xfer(1'b0, a, 32'h0, v);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    check(v, e);
  endtask
  task automatic closeOut();
    $display("Counts: %0d compares, %0d mismatches", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reference power per tick: gain, offset, then divide toward zero
  function automatic longint power(longint s, logic [11:0] g, logic [11:0] o, logic [7:0] dv);
    longint p;
    p = ((s * (4096 + longint'($signed(g)))) >>> 12) + longint'($signed(o));
    if (dv > 1) p = p / longint'(dv);
    return p;
  endfunction
  function automatic logic [31:0] eng(longint p, int k);
    longint a;
    a = (p * k) >>> 25;
    return {16'h0, a[15:0]};
  endfunction

  // Watchdog: about four times the expected run
  initial begin
    repeat (5000) @(posedge ref_clk);
    nErrors++;
    closeOut();
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    logic [11:0] g [PHASES];
    logic [11:0] o [PHASES];
    longint      s [5];
    longint      sel [PHASES];
    longint      pw [PHASES];
    logic [7:0]  dv;
    logic [31:0] q;
    logic [31:0] e0;
    logic [31:0] e1;
    seed = 15288;
    nErrors = 0;
    testsRun = 0;
    rst = 1'b1;
    samples = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rdc(ADDR_COMP_MODE, 32'h1c);
    rdc(ADDR_STATUS, 32'h0);
    rdc(5'h1f, 32'h0);
    check({31'h0, irqN}, 32'h1);
    wr(ADDR_INTEG, 32'h1);
    check({31'h0, phaseShiftNeg}, 32'h1);
    wr(ADDR_INTEG, 32'h0);
    check({31'h0, phaseShiftNeg}, 32'h0);
    for (int a = 0; a < 7; a++) begin
      q = $random(seed);
      wr(5'(a), q);
      rdc(5'(a), q & (a == 6 ? 32'hff : 32'hfff));
    end
    $display("Test reset and map done");
    // Read-clears on, so each window starts from zero
    wr(ADDR_LINE_MODE, 32'h40);
    for (int m = 0; m < 4; m++) begin
      dv = (m == 1) ? 8'h1 : 8'(m * 5);
      for (int i = 0; i < PHASES; i++) begin
        g[i] = (i == 0) ? (m[0] ? 12'h800 : 12'h7ff) : 12'($random(seed));
        o[i] = 12'($random(seed));
        wr(5'(ADDR_GAIN_A + i), {20'h0, g[i]});
        wr(5'(ADDR_OFFSET_A + i), {20'h0, o[i]});
      end
      wr(ADDR_DIVIDER, {24'h0, dv});
      wr(ADDR_COMP_MODE, 32'h1c | m);
      for (int i = 0; i < 5; i++) s[i] = $random(seed) % (1 << 22);
      samples <= '{own: {24'(s[2]), 24'(s[1]), 24'(s[0])}, crossB: {24'(s[4]), 24'(s[3])}};
      sel[0] = (m == 3) ? 0 : (m == 0) ? s[0] : s[0] - s[3];
      sel[1] = (m == 0) ? s[1] : 0;
      sel[2] = (m == 3) ? 0 : (m == 1) ? s[2] - s[4] : s[2];
      for (int i = 0; i < PHASES; i++) pw[i] = power(sel[i], g[i], o[i], dv);
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < PHASES; i++) rd(5'(ADDR_ENERGY_A + i), q);
      wr(ADDR_ENERGY_A, 32'hffff); // Must be ignored
      repeat (4 * K - 8) @(posedge ref_clk);
      for (int i = 0; i < PHASES; i++) begin
        rd(5'(ADDR_ENERGY_A + i), q);
        e0 = eng(pw[i], K);
        e1 = eng(pw[i], K - 1);
        check(q, (q === e1) ? e1 : e0);
      end
      $display("Test connection mode %0d done", m);
    end
    // Phase A excluded while it turns negative, then included as it turns back
    wr(ADDR_COMP_MODE, 32'h1c);
    samples <= '{own: {3{24'h400000}}, crossB: 48'h0};
    repeat (200) @(posedge ref_clk);
    wr(ADDR_STATUS, 32'hffffffff);
    rdc(ADDR_STATUS, 32'h0);
    wr(ADDR_COMP_MODE, 32'h18);
    wr(ADDR_MASK, 32'h40000);
    samples <= '{own: {24'h400000, 24'h400000, 24'hc00000}, crossB: 48'h0};
    repeat (400) @(posedge ref_clk);
    rdc(ADDR_STATUS, 32'h2);
    check({31'h0, irqN}, 32'h1);
    wr(ADDR_COMP_MODE, 32'h1c);
    samples <= '{own: {3{24'h400000}}, crossB: 48'h0};
    repeat (200) @(posedge ref_clk);
    rdc(ADDR_STATUS, 32'h40002);
    check({31'h0, irqN}, 32'h0);
    wr(ADDR_STATUS, 32'h40000);
    check({31'h0, irqN}, 32'h1);
    wr(ADDR_MASK, 32'h2);
    check({31'h0, irqN}, 32'h0);
    wr(ADDR_MASK, 32'h0);
    check({31'h0, irqN}, 32'h1);
    $display("Test sign and interrupt done");
    closeOut();
  end
endmodule // rea_accumulator_tb_top

`default_nettype wire
